// ---- rtl/sbsr_regs.svh ----
`ifndef SBSR_REGS_SVH
`define SBSR_REGS_SVH
// Status byte bit positions
`define SBSR_OPER_SUM_POS    3'h7
`define SBSR_MASTER_POS      3'h6
`define SBSR_EVENT_SUM_POS   3'h5
`define SBSR_MSG_WAIT_POS    3'h4
// Standard event bit positions
`define SBSR_DONE_FLAG_POS   3'h0
// Reset and fixed values
`define SBSR_SRE_RST         8'h00
`define SBSR_SE_RST          8'h00
`define SBSR_ZERO8           8'h00
`define SBSR_ZERO4           4'h0
`define SBSR_DONE_REPLY      8'h01
// Summary bits that may request service (bits 3..0 have no function)
`define SBSR_SUMMARY_MASK    8'hB0
`endif

// ---- rtl/sbsr_pkg.sv ----
package sbsr_pkg;
	typedef logic [7:0] sbsr_byte_t;
	typedef enum logic [1:0] {
		SBSR_DONE_IDLE,
		SBSR_DONE_ARMED,
		SBSR_DONE_QUERY
	} sbsr_done_state_t;

	// Places one flag at a bit position of an otherwise clear byte
	function automatic sbsr_byte_t sbsr_bit_at(input logic b, input logic [2:0] pos);
		sbsr_byte_t v;
		v = '0;
		v[pos] = b;
		return v;
	endfunction
endpackage

// ---- rtl/sbsr_std_event.sv ----
`timescale 1ns/1ps
`include "sbsr_regs.svh"
// Standard event register, its enable mask and the summary it drives
module sbsr_std_event (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Event inputs
	input  wire sbsr_pkg::sbsr_byte_t se_events,
	input  wire logic              done_set,
	// Register access
	input  wire logic              ese_write,
	input  wire sbsr_pkg::sbsr_byte_t ese_wdata,
	input  wire logic              esr_read,
	input  wire logic              clear_all,
	// State
	output logic [7:0]             se_status_q,
	output logic [7:0]             se_enable_q,
	output logic                   event_summary
);
	import sbsr_pkg::*;

	sbsr_byte_t se_set;
	sbsr_byte_t se_d;

	assign se_set = se_events | sbsr_bit_at(done_set, `SBSR_DONE_FLAG_POS);
	// Set beats the read-clear so an event in the read cycle is kept
	assign se_d = ((esr_read || clear_all) ? `SBSR_ZERO8 : se_status_q) | se_set;
	assign event_summary = |(se_status_q & se_enable_q);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			se_status_q <= `SBSR_SE_RST;
			se_enable_q <= `SBSR_ZERO8;
		end else begin
			se_status_q <= se_d;
			if (ese_write) begin
				se_enable_q <= ese_wdata;
			end
		end
	end

	a_read_clears: assert property (@(posedge clock) disable iff (rst)
		(esr_read && !clear_all && se_set == `SBSR_ZERO8) |=> (se_status_q == `SBSR_ZERO8))
		else $error("event register not cleared by read");
	a_event_summary: assert property (@(posedge clock) disable iff (rst)
		(|(se_set & se_enable_q) && !ese_write) |=> event_summary)
		else $error("event summary does not follow masked events");
endmodule

// ---- rtl/sbsr_status_byte.sv ----
`timescale 1ns/1ps
`include "sbsr_regs.svh"
// Contract
// - Operation summary at bit 7 set while an enabled operation event stands.
// - Standard event summary at bit 5 set while an enabled standard event stands.
// - Message waiting at bit 4 follows output buffer non-empty, query replies included.
// - Summary flags do not latch; they follow their sources directly.
// - Master summary is OR of each summary ANDed with its enable bit.
// - Bit 6 set when any summary and its enable bit are both set.
// - Rising edge of bit 6 asserts service request and request service flag.
// - Serial poll clears request service and service request, not master summary.
// - No new request after poll until the master summary has dropped.
// - Master summary holds until all enabled summaries cleared or disabled.
// - Status query returns all bits, bit 6 as master summary, clears nothing.
// - Enable write loads service request mask; enable query returns it.
// - After operation-complete command, set event bit 0 once operations finish.
// - Operation-complete query holds bus until idle, then queues value 1.
// - Standard event query returns contents, then clears the register.
// - Standard event summary uses standard events masked by their enable register.
module sbsr_status_byte (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Summary sources
	input  wire logic                 oper_summary,
	input  wire logic                 outbuf_not_empty,
	input  wire sbsr_pkg::sbsr_byte_t se_events,
	input  wire logic                 ops_pending,
	// Commands from the parser
	input  wire logic                 sre_write,
	input  wire sbsr_pkg::sbsr_byte_t sre_wdata,
	input  wire logic                 sre_query,
	input  wire logic                 stb_query,
	input  wire logic                 ese_write,
	input  wire sbsr_pkg::sbsr_byte_t ese_wdata,
	input  wire logic                 ese_query,
	input  wire logic                 esr_query,
	input  wire logic                 done_cmd,
	input  wire logic                 done_query,
	input  wire logic                 clear_status,
	input  wire logic                 device_reset,
	// Bus side
	input  wire logic                 serial_poll,
	output logic                      srq_q,
	output sbsr_pkg::sbsr_byte_t      poll_byte_q,
	output logic                      bus_hold_q,
	// Reply to output buffer
	output logic                      reply_valid_q,
	output sbsr_pkg::sbsr_byte_t      reply_data_q,
	// Status
	output sbsr_pkg::sbsr_byte_t      status_summary_byte_q,
	output sbsr_pkg::sbsr_byte_t      service_request_mask_q
);
	import sbsr_pkg::*;

	sbsr_done_state_t done_state_q;
	sbsr_done_state_t done_state_d;
	logic             request_service_flag_q;
	logic             master_prev_q;
	logic [7:0]       se_status;
	logic [7:0]       se_enable;
	logic             standard_event_summary_flag;
	logic             done_set;
	logic [7:0]       masked_bits;

	// Summaries are plain wires so clearing a source drops the flag at once
	wire logic       operation_summary_flag = oper_summary;
	wire logic       message_waiting_flag   = outbuf_not_empty;
	wire sbsr_byte_t summary_bits = (sbsr_bit_at(operation_summary_flag, `SBSR_OPER_SUM_POS)
		| sbsr_bit_at(standard_event_summary_flag, `SBSR_EVENT_SUM_POS)
		| sbsr_bit_at(message_waiting_flag, `SBSR_MSG_WAIT_POS)) & `SBSR_SUMMARY_MASK;

	// One AND per status bit against its enable bit
	for (genvar i = 0; i < 8; i++) begin : g_mask
		assign masked_bits[i] = summary_bits[i] & service_request_mask_q[i];
	end

	wire logic       master_summary_flag = |masked_bits;
	// Only an edge requests service, so a held summary cannot request twice
	wire logic       master_rise = master_summary_flag && !master_prev_q;
	wire sbsr_byte_t stb_value = summary_bits |
		sbsr_bit_at(master_summary_flag, `SBSR_MASTER_POS);
	wire sbsr_byte_t poll_value = summary_bits |
		sbsr_bit_at(request_service_flag_q || master_rise, `SBSR_MASTER_POS);

	sbsr_std_event sbsr_std_event_i (
		.clock         (clock),
		.rst           (rst),
		.se_events     (se_events),
		.done_set      (done_set),
		.ese_write     (ese_write),
		.ese_wdata     (ese_wdata),
		.esr_read      (esr_query),
		.clear_all     (clear_status || device_reset),
		.se_status_q   (se_status),
		.se_enable_q   (se_enable),
		.event_summary (standard_event_summary_flag)
	);

	// Command and query replies; priority among queries of one cycle is fixed
	wire logic       done_reply = (done_state_q == SBSR_DONE_QUERY) && !ops_pending;
	wire logic       any_reply = done_reply || stb_query || sre_query || ese_query || esr_query;
	wire sbsr_byte_t reply_sel = done_reply ? `SBSR_DONE_REPLY :
		stb_query ? stb_value :
		sre_query ? service_request_mask_q :
		ese_query ? se_enable : se_status;
	assign done_set = (done_state_q == SBSR_DONE_ARMED) && !ops_pending;

	always_comb begin
		done_state_d = done_state_q;
		case (done_state_q)
			SBSR_DONE_IDLE: begin
				if (done_query) begin
					done_state_d = SBSR_DONE_QUERY;
				end else if (done_cmd) begin
					done_state_d = SBSR_DONE_ARMED;
				end
			end
			SBSR_DONE_ARMED: begin
				// Other commands keep flowing while armed
				if (done_query) begin
					done_state_d = SBSR_DONE_QUERY;
				end else if (!ops_pending) begin
					done_state_d = SBSR_DONE_IDLE;
				end
			end
			SBSR_DONE_QUERY: begin
				if (!ops_pending) begin
					done_state_d = SBSR_DONE_IDLE;
				end
			end
			default: done_state_d = SBSR_DONE_IDLE;
		endcase
		// Device reset is the one command allowed to cut a waiting query short
		if (device_reset) begin
			done_state_d = SBSR_DONE_IDLE;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			done_state_q <= SBSR_DONE_IDLE;
			master_prev_q <= 1'h0;
			request_service_flag_q <= 1'h0;
			srq_q <= 1'h0;
			poll_byte_q <= `SBSR_ZERO8;
			bus_hold_q <= 1'h0;
			reply_valid_q <= 1'h0;
			reply_data_q <= `SBSR_ZERO8;
			status_summary_byte_q <= `SBSR_ZERO8;
			service_request_mask_q <= `SBSR_SRE_RST;
		end else begin
			done_state_q <= done_state_d;
			master_prev_q <= master_summary_flag;
			// New rising edge wins over a poll in the same cycle
			if (master_rise) begin
				request_service_flag_q <= 1'h1;
			end else if (serial_poll) begin
				request_service_flag_q <= 1'h0;
			end
			srq_q <= master_rise || (request_service_flag_q && !serial_poll);
			if (serial_poll) begin
				poll_byte_q <= poll_value;
			end
			bus_hold_q <= (done_state_d == SBSR_DONE_QUERY);
			reply_valid_q <= any_reply;
			if (any_reply) begin
				reply_data_q <= reply_sel;
			end
			status_summary_byte_q <= stb_value;
			if (sre_write) begin
				service_request_mask_q <= sre_wdata & `SBSR_SUMMARY_MASK;
			end
		end
	end

	a_srq_on_rise: assert property (@(posedge clock) disable iff (rst)
		(master_summary_flag && !master_prev_q) |=> (srq_q && request_service_flag_q))
		else $error("no service request after master summary rise");
	a_poll_clears: assert property (@(posedge clock) disable iff (rst)
		(serial_poll && !master_rise) |=> (!request_service_flag_q && !srq_q))
		else $error("serial poll did not clear request");
	a_no_rerequest: assert property (@(posedge clock) disable iff (rst)
		(master_prev_q && master_summary_flag) |=> (srq_q == $past(srq_q && !serial_poll)))
		else $error("request raised without new rise");
	a_master_follow: assert property (@(posedge clock) disable iff (rst)
		##1 status_summary_byte_q[`SBSR_MASTER_POS] ==
		$past(|(summary_bits & service_request_mask_q)))
		else $error("bit six wrong");
	a_low_zero: assert property (@(posedge clock) disable iff (rst)
		status_summary_byte_q[3:0] == `SBSR_ZERO4 &&
		service_request_mask_q[3:0] == `SBSR_ZERO4)
		else $error("low status bits not zero");
	a_msg_follow: assert property (@(posedge clock) disable iff (rst)
		##1 status_summary_byte_q[`SBSR_MSG_WAIT_POS] == $past(outbuf_not_empty))
		else $error("message waiting flag not following buffer");
	a_sre_load: assert property (@(posedge clock) disable iff (rst)
		sre_write |=> service_request_mask_q == ($past(sre_wdata) & `SBSR_SUMMARY_MASK))
		else $error("mask not loaded");
	a_done_reply: assert property (@(posedge clock) disable iff (rst)
		(done_state_q == SBSR_DONE_QUERY && !ops_pending) |=>
		(reply_valid_q && reply_data_q == `SBSR_DONE_REPLY && !bus_hold_q))
		else $error("operation complete reply missing");
	a_done_bit: assert property (@(posedge clock) disable iff (rst)
		(done_state_q == SBSR_DONE_ARMED && !ops_pending && !device_reset) |=>
		se_status[`SBSR_DONE_FLAG_POS])
		else $error("operation complete flag not set");
	a_stb_noclear: assert property (@(posedge clock) disable iff (rst)
		(stb_query && !sre_write && !serial_poll && !master_rise) |=>
		request_service_flag_q == $past(request_service_flag_q))
		else $error("status query changed request flag");

	// Main scenarios worth seeing in a run
	c_srq: cover property (@(posedge clock) disable iff (rst) master_rise ##[1:20] serial_poll);
	c_done_q: cover property (@(posedge clock) disable iff (rst) done_query ##[1:50] done_reply);
	c_done_c: cover property (@(posedge clock) disable iff (rst) done_cmd ##[1:50] done_set);
	c_esr: cover property (@(posedge clock) disable iff (rst)
		esr_query && standard_event_summary_flag);
	c_rise_poll: cover property (@(posedge clock) disable iff (rst) master_rise && serial_poll);
endmodule

// ---- test/sbsr_bus_ctrl.sv ----
`timescale 1ns/1ps
// Bus controller: answers a service request with a serial poll on the DLY+1th falling edge that sees srq high
module sbsr_bus_ctrl #(
	parameter int DLY = 3
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Bus side of the device
	input  wire logic                 srq,
	input  wire sbsr_pkg::sbsr_byte_t poll_byte,
	output logic                      serial_poll,
	output logic                      found
);
	import sbsr_pkg::*;
	int cnt;
	// Poll on request, the polled byte names the requester
	always @(negedge clock or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			serial_poll <= 1'b0;
			found <= 1'b0;
		end else begin
			serial_poll <= 1'b0;
			if (serial_poll)
				found <= poll_byte[6];
			if (!srq || serial_poll)
				cnt <= 0;
			else if (cnt == DLY) begin
				serial_poll <= 1'b1;
				cnt <= 0;
			end else
				cnt <= cnt + 1;
		end
	end
endmodule

// ---- test/test_sbsr_status_byte.sv ----
`timescale 1ns/1ps
module test_status_byte_service_request;
	import sbsr_pkg::*;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic [9:0] c = 10'h000;
	logic       oper = 1'b0;
	logic       outbuf = 1'b0;
	logic       ops = 1'b0;
	sbsr_byte_t se = 8'h00;
	sbsr_byte_t wd = 8'h00;
	logic       poll;
	logic       found;
	logic       srq;
	logic       hold;
	logic       rv;
	sbsr_byte_t pb;
	sbsr_byte_t rd;
	sbsr_byte_t stat;
	sbsr_byte_t mask;
	int         err_count = 0;
	int         n_compared = 0;

	always #2 clock = ~clock;

	sbsr_status_byte sbsr_status_byte_i (.clock(clock), .rst(rst), .oper_summary(oper),
		.outbuf_not_empty(outbuf), .se_events(se), .ops_pending(ops), .sre_write(c[0]),
		.sre_wdata(wd), .sre_query(c[1]), .stb_query(c[2]), .ese_write(c[3]), .ese_wdata(wd),
		.ese_query(c[4]), .esr_query(c[5]), .done_cmd(c[6]), .done_query(c[7]),
		.clear_status(c[8]), .device_reset(c[9]), .serial_poll(poll), .srq_q(srq),
		.poll_byte_q(pb), .bus_hold_q(hold), .reply_valid_q(rv), .reply_data_q(rd),
		.status_summary_byte_q(stat), .service_request_mask_q(mask));
	sbsr_bus_ctrl sbsr_bus_ctrl_i (.clock(clock), .rst(rst), .srq(srq), .poll_byte(pb),
		.serial_poll(poll), .found(found));

	task automatic results;
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input sbsr_byte_t got, input sbsr_byte_t exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask
	// One-cycle command pulse, one edge sees it
	task automatic pulse(input int k);
		c = 10'h001 << k;
		step(1);
		c = 10'h000;
	endtask
	task automatic query(input int k, input sbsr_byte_t exp);
		pulse(k);
		chk({7'h00, rv}, 8'h01);
		chk(rd, exp);
	endtask
	task automatic event_pulse(input sbsr_byte_t v);
		se = v;
		step(1);
		se = 8'h00;
		step(2);
	endtask

	// Whole run is about 80 cycles
	initial begin
		#(4 * 3000);
		err_count++;
		results;
	end

	initial begin
		step(20);
		rst = 1'b0;
		step(1);
		chk(stat, 8'h00);
		chk(mask, 8'h00);
		wd = 8'hFF;
		pulse(0);
		step(1);
		chk(mask, 8'hB0);
		query(1, 8'hB0);
		oper = 1'b1;
		step(1);
		chk(stat, 8'hC0);
		chk({7'h00, srq}, 8'h01);
		step(6);
		chk({7'h00, srq}, 8'h00);
		chk({7'h00, found}, 8'h01);
		chk(pb, 8'hC0);
		chk(stat, 8'hC0);
		query(2, 8'hC0);
		step(4);
		chk(stat, 8'hC0);
		chk({7'h00, srq}, 8'h00);
		wd = 8'h00;
		pulse(0);
		step(2);
		chk(stat, 8'h80);
		wd = 8'hB0;
		pulse(0);
		step(2);
		chk(stat, 8'hC0);
		oper = 1'b0;
		step(2);
		chk(stat, 8'h00);
		outbuf = 1'b1;
		step(2);
		chk(stat, 8'h50);
		outbuf = 1'b0;
		step(2);
		chk(stat, 8'h00);
		wd = 8'h20;
		pulse(3);
		query(4, 8'h20);
		event_pulse(8'h04);
		chk(stat, 8'h00);
		event_pulse(8'h20);
		chk(stat, 8'h60);
		pulse(8);
		step(2);
		chk(stat, 8'h00);
		event_pulse(8'h20);
		query(5, 8'h20);
		step(2);
		chk(stat, 8'h00);
		query(5, 8'h00);
		ops = 1'b1;
		pulse(6);
		step(3);
		query(5, 8'h00);
		ops = 1'b0;
		step(3);
		query(5, 8'h01);
		ops = 1'b1;
		pulse(7);
		step(3);
		chk({7'h00, hold}, 8'h01);
		// Nothing else goes out while the query waits
		ops = 1'b0;
		step(1);
		chk({6'h00, hold, rv}, 8'h01);
		chk(rd, 8'h01);
		query(5, 8'h00);
		results;
	end
endmodule
